// file: rtl/burst_sram_pkg.sv
// shared widths, encodings and state layouts of the pipelined burst memory port
package burst_sram_pkg;

  // array geometry: 512K words of four 9-bit lanes (eight data bits plus parity each)
  localparam int ADDR_W = 19;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int MEM_DEPTH = 1 << ADDR_W;

  // burst counter touches only the two lowest address bits
  localparam int BEAT_W = 2;
  localparam int HI_W = ADDR_W - BEAT_W;
  localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_STEP = 2'h1;

  // write buffer between the input stage and the array
  localparam int BUF_ENTRIES = 2;
  localparam int BUF_CNT_W = 2;
  localparam logic [BUF_CNT_W-1:0] BUF_EMPTY = 2'h0;
  localparam logic [BUF_CNT_W-1:0] BUF_FULL = 2'h2;
  localparam logic [BUF_CNT_W-1:0] BUF_ONE = 2'h1;

  typedef enum logic [1:0] {
    ST_DESELECTED = 2'b00,
    ST_BURST = 2'b01,
    ST_SLEEP = 2'b10
  } burst_state_t;

  // bus inputs as captured, every control already turned active high
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic sel_primary;
    logic sel_high;
    logic sel_low;
    logic proc_strobe;
    logic ctrl_strobe;
    logic advance;
    logic global_wr;
    logic byte_wr_en;
    logic [LANES-1:0] lane_wr;
  } bus_in_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0] mask;
  } wr_entry_t;

  typedef struct packed {
    bus_in_t in;
    logic mode_meta;
    logic mode_sync;
    logic sleep_meta;
    logic sleep_sync;
    burst_state_t st;
    logic [HI_W-1:0] base_hi;
    logic [BEAT_W-1:0] base_lo;
    logic [BEAT_W-1:0] beat;
    wr_entry_t [BUF_ENTRIES-1:0] fifo;
    logic [BUF_CNT_W-1:0] fifo_cnt;
    logic fifo_head;
    logic rd_s1;
    logic desel_s1;
    logic [DATA_W-1:0] fwd_data_s1;
    logic [LANES-1:0] fwd_mask_s1;
    logic drive;
    logic hold;
    logic [DATA_W-1:0] dq_out;
    logic write_ready;
  } port_state_t;

endpackage

// file: rtl/burst_sram_array.sv
// single-port storage array with lane write mask and registered read data
`timescale 1ns/1ns
module burst_sram_array
  import burst_sram_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic en,
  input wire logic we,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [LANES-1:0] wmask,
  output logic [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] mem [MEM_DEPTH];
  logic [DATA_W-1:0] rdata_r;

  // lanes are written independently, the others keep their contents;
  // one process owns the whole array so no word has two writers
  always_ff @(posedge clock)
  begin
    for (int l = 0; l < LANES; l++)
    begin
      if (en && we && wmask[l])
      begin
        mem[addr][l*LANE_W +: LANE_W] <= wdata[l*LANE_W +: LANE_W];
      end
    end
  end

  // read data holds between reads so the output stage may re-sample it
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      rdata_r <= '0;
    end
    else if (en && !we)
    begin
      rdata_r <= mem[addr];
    end
  end

  assign rdata = rdata_r;

endmodule

// file: rtl/pipelined_burst_sram_port.sv
// synchronous pipelined burst memory port with double-cycle deselect
//
// Operation
// - every synchronous input is captured on the rising clock edge
// - either address strobe starts an access, latching address and chip selects
// - later burst addresses come from an internal counter stepped by burst advance
// - the counter is two bits and alters only the two lowest address bits
// - burst order is interleaved or linear as the mode input selects
// - first beat after three cycles, then one beat per cycle
// - inputs and read data are both registered, so accesses pipeline
// - writes register address, data and controls, then finish self-timed
// - byte lane controls pick any one to four lanes to write
// - global write low writes all lanes regardless of lane controls
// - after a deselect the data drivers stay on one further cycle
// - output enable and sleep request act asynchronously on the drivers
// - array holds 512K words of four 9-bit lanes with parity bit
// - depth-expansion selects are sampled like the primary select
`timescale 1ns/1ns
module pipelined_burst_sram_port
  import burst_sram_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic chip_select_primary_n,
  input wire logic depth_select_high,
  input wire logic depth_select_low_n,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic [LANES-1:0] byte_lane_write_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_linear,
  input wire logic array_stall,
  output logic write_ready
);

  localparam port_state_t STATE_RESET = '0;

  port_state_t s_r;
  port_state_t s_nxt;

  logic selected;
  logic strobe;
  logic wr_req;
  logic [LANES-1:0] wr_mask;
  logic access;
  logic rd_now;
  logic wr_now;
  logic desel_now;
  logic [ADDR_W-1:0] acc_addr;
  logic [BEAT_W-1:0] lo_addr;
  logic [BEAT_W-1:0] beat_next;

  wr_entry_t older;
  wr_entry_t newer;
  wr_entry_t incoming;
  logic older_match;
  logic newer_match;
  logic [LANES-1:0] fwd_hit;
  logic [DATA_W-1:0] fwd_data;
  logic [DATA_W-1:0] merged;

  logic pop;
  logic direct;
  logic push;
  logic tail;

  logic mem_en;
  logic mem_we;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] mem_wdata;
  logic [LANES-1:0] mem_wmask;
  logic [DATA_W-1:0] mem_rdata;

  // interleaved order flips counter bits into the start address, linear adds
  function automatic logic [BEAT_W-1:0] burst_lo(
    input logic linear,
    input logic [BEAT_W-1:0] start,
    input logic [BEAT_W-1:0] beat
  );
    logic [BEAT_W-1:0] r;
    r = start ^ beat;
    if (linear)
    begin
      r = BEAT_W'(start + beat);
    end
    return r;
  endfunction

  // decode of the cycle presented one edge earlier
  assign selected = s_r.in.sel_primary & s_r.in.sel_high & s_r.in.sel_low;
  assign strobe = s_r.in.proc_strobe | s_r.in.ctrl_strobe;
  // with neither write control the cycle is a read
  assign wr_req = s_r.in.global_wr | (s_r.in.byte_wr_en & (|s_r.in.lane_wr));
  assign wr_mask = s_r.in.global_wr ? '1 :
                   (s_r.in.byte_wr_en ? s_r.in.lane_wr : '0);

  assign older = s_r.fifo[s_r.fifo_head];
  assign newer = s_r.fifo[~s_r.fifo_head];
  assign older_match = (s_r.fifo_cnt != BUF_EMPTY) && (older.addr == acc_addr);
  assign newer_match = (s_r.fifo_cnt == BUF_FULL) && (newer.addr == acc_addr);

  // per lane: forward buffered write data to a read, and merge it at the output
  for (genvar l = 0; l < LANES; l++)
  begin : g_lane
    logic old_hit;
    logic new_hit;
    assign old_hit = older_match & older.mask[l];
    assign new_hit = newer_match & newer.mask[l];
    assign fwd_hit[l] = old_hit | new_hit;
    assign fwd_data[l*LANE_W +: LANE_W] = new_hit ? newer.data[l*LANE_W +: LANE_W] :
                                                    older.data[l*LANE_W +: LANE_W];
    assign merged[l*LANE_W +: LANE_W] = s_r.fwd_mask_s1[l] ?
                                        s_r.fwd_data_s1[l*LANE_W +: LANE_W] :
                                        mem_rdata[l*LANE_W +: LANE_W];
  end

  always_comb
  begin
    s_nxt = s_r;
    access = 1'b0;
    desel_now = 1'b0;
    acc_addr = s_r.in.addr;
    beat_next = s_r.beat;
    lo_addr = s_r.base_lo;

    // input register stage, active-low controls inverted to active high
    s_nxt.in.addr = addr;
    s_nxt.in.data = dq_in;
    s_nxt.in.sel_primary = ~chip_select_primary_n;
    s_nxt.in.sel_high = depth_select_high;
    s_nxt.in.sel_low = ~depth_select_low_n;
    s_nxt.in.proc_strobe = ~processor_addr_strobe_n;
    s_nxt.in.ctrl_strobe = ~controller_addr_strobe_n;
    s_nxt.in.advance = ~burst_advance_n;
    s_nxt.in.global_wr = ~global_write_n;
    s_nxt.in.byte_wr_en = ~byte_write_enable_n;
    s_nxt.in.lane_wr = ~byte_lane_write_n;

    // mode is a strap and sleep an asynchronous level: both are synchronised
    s_nxt.mode_meta = burst_linear;
    s_nxt.mode_sync = s_r.mode_meta;
    s_nxt.sleep_meta = sleep_request;
    s_nxt.sleep_sync = s_r.sleep_meta;

    if (s_r.sleep_sync)
    begin
      // asleep the port ignores the bus; a burst in flight is abandoned
      s_nxt.st = ST_SLEEP;
    end
    else if (strobe)
    begin
      if (selected)
      begin
        s_nxt.st = ST_BURST;
        s_nxt.base_hi = s_r.in.addr[ADDR_W-1:BEAT_W];
        s_nxt.base_lo = s_r.in.addr[BEAT_W-1:0];
        s_nxt.beat = BEAT_FIRST;
        access = 1'b1;
        acc_addr = s_r.in.addr;
      end
      else
      begin
        s_nxt.st = ST_DESELECTED;
        desel_now = 1'b1;
      end
    end
    else
    begin
      case (s_r.st)
        ST_BURST:
        begin
          // without advance the same location is accessed again
          if (s_r.in.advance)
          begin
            beat_next = BEAT_W'(s_r.beat + BEAT_STEP);
          end
          lo_addr = burst_lo(s_r.mode_sync, s_r.base_lo, beat_next);
          s_nxt.beat = beat_next;
          access = 1'b1;
          acc_addr = {s_r.base_hi, lo_addr};
        end
        ST_SLEEP:
        begin
          s_nxt.st = ST_DESELECTED;
        end
        ST_DESELECTED:
        begin
          s_nxt.st = ST_DESELECTED;
        end
        default:
        begin
          s_nxt.st = ST_DESELECTED;
        end
      endcase
    end

    rd_now = access & ~wr_req;
    wr_now = access & wr_req;
    incoming.addr = acc_addr;
    incoming.data = s_r.in.data;
    incoming.mask = wr_mask;

    // reads own the array; buffered writes drain in any other cycle without array_stall
    pop = (s_r.fifo_cnt != BUF_EMPTY) & ~rd_now & ~array_stall;
    direct = (s_r.fifo_cnt == BUF_EMPTY) & wr_now & ~array_stall;
    // a write arriving while the buffer stays full is lost, write_ready warns
    push = wr_now & ~direct & ((s_r.fifo_cnt != BUF_FULL) | pop);
    tail = s_r.fifo_head ^ s_r.fifo_cnt[0];
    if (push)
    begin
      s_nxt.fifo[tail] = incoming;
    end
    if (pop)
    begin
      s_nxt.fifo_head = ~s_r.fifo_head;
    end
    s_nxt.fifo_cnt = BUF_CNT_W'(s_r.fifo_cnt + (push ? BUF_ONE : BUF_EMPTY)
                                - (pop ? BUF_ONE : BUF_EMPTY));
    s_nxt.write_ready = (s_nxt.fifo_cnt != BUF_FULL);

    // self-timed array write, no further bus timing needed
    mem_en = rd_now | pop | direct;
    mem_we = pop | direct;
    mem_addr = acc_addr;
    mem_wdata = incoming.data;
    mem_wmask = incoming.mask;
    if (pop)
    begin
      mem_addr = older.addr;
      mem_wdata = older.data;
      mem_wmask = older.mask;
    end

    // array read stage: note which lanes still sit in the buffer
    s_nxt.rd_s1 = rd_now;
    s_nxt.desel_s1 = desel_now | s_r.sleep_sync;
    s_nxt.fwd_data_s1 = fwd_data;
    s_nxt.fwd_mask_s1 = rd_now ? fwd_hit : '0;

    // output register stage: first beat on the pins two edges after capture
    if (s_r.rd_s1)
    begin
      s_nxt.dq_out = merged;
    end
    s_nxt.drive = s_r.rd_s1;
    // extra enable stage keeps the drivers on across a deselect
    s_nxt.hold = s_r.drive & s_r.desel_s1 & ~s_r.rd_s1;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      s_r <= STATE_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  burst_sram_array u_array (
    .clock(clock),
    .reset(reset),
    .en(mem_en),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .wmask(mem_wmask),
    .rdata(mem_rdata)
  );

  assign dq_out = s_r.dq_out;
  assign write_ready = s_r.write_ready;
  // gated without the clock so the bus can be released at once
  assign dq_oe = (s_r.drive | s_r.hold) & ~output_enable_n & ~sleep_request;

endmodule

// file: verif/burst_port_chk.sv
// pin-level assertions for the pipelined burst memory port
`timescale 1ns/1ns
module burst_port_chk
  import burst_sram_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic chip_select_primary_n,
  input wire logic depth_select_high,
  input wire logic depth_select_low_n,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic [LANES-1:0] byte_lane_write_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_linear,
  input wire logic array_stall,
  input wire logic write_ready
);
  logic strb;
  logic sel;
  logic wr;
  logic rd;
  logic quiet;
  assign strb = !processor_addr_strobe_n || !controller_addr_strobe_n;
  assign sel = !chip_select_primary_n && depth_select_high && !depth_select_low_n;
  assign wr = strb && sel && (!global_write_n || (!byte_write_enable_n && !(&byte_lane_write_n)));
  assign rd = strb && sel && !wr;
  // the sleep pin reaches the bus logic two edges late, so reads count only after a calm spell
  assign quiet = !sleep_request && !output_enable_n;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  oe_gate_a: assert property (output_enable_n |-> !dq_oe)
    else $error("drivers on with output enable inactive");
  sleep_gate_a: assert property (sleep_request |-> !dq_oe)
    else $error("drivers on during sleep request");
  read_lat_a: assert property (quiet[*4] ##0 rd |-> ##3 dq_oe)
    else $error("read data not driven three cycles after its address");
  burst_drive_a: assert property (quiet[*4] ##0 rd ##1 (!strb && !burst_advance_n)[*3]
    |-> dq_oe[*4])
    else $error("burst beats not driven on consecutive cycles");
  desel_hold_a: assert property (quiet[*4] ##0 rd ##1 (strb && !sel) ##1 !strb
    |-> ##1 dq_oe ##1 dq_oe ##1 !dq_oe)
    else $error("drivers not held exactly one cycle after deselect");
  unsel_quiet_a: assert property (strb && !sel ##1 (!strb)[*3] |=> !dq_oe)
    else $error("drivers on after an unselected strobe");
  sleep_quiet_a: assert property (sleep_request ##1 (!sleep_request && !strb)[*7] |=> !dq_oe)
    else $error("drivers on after sleep without a new access");
  // the stall pin acts one cycle after the write it blocks, so it must still stand then
  write_full_a: assert property ((wr && array_stall)[*2] ##1 array_stall |-> ##[0:1] !write_ready)
    else $error("write ready high with two stalled writes");
endmodule

bind pipelined_burst_sram_port burst_port_chk burst_port_chk_i (.clock, .reset, .addr, .dq_in,
  .dq_out, .dq_oe, .chip_select_primary_n, .depth_select_high, .depth_select_low_n,
  .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_advance_n, .global_write_n,
  .byte_write_enable_n, .byte_lane_write_n, .output_enable_n, .sleep_request, .burst_linear,
  .array_stall, .write_ready);

// file: verif/ctrl_capture.sv
// controller-side model that samples read data off the shared bus
`timescale 1ns/1ns
module ctrl_capture
  import burst_sram_pkg::*;
(
  input wire logic clock,
  input wire logic dq_oe,
  input wire logic [DATA_W-1:0] dq_out,
  output logic [DATA_W-1:0] seen_r
);
  // an undriven bus must not look like the last word, so it flips instead
  always_ff @(posedge clock)
  begin
    seen_r <= dq_oe ? dq_out : ~seen_r;
  end
endmodule

// file: verif/pipelined_burst_sram_port_tb.sv
// self-checking testbench of the pipelined burst memory port
`timescale 1ns/1ns
module pipelined_burst_sram_port_tb;
  import burst_sram_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] dq_in = '0;
  logic [DATA_W-1:0] dq_out;
  logic dq_oe;
  logic chip_select_primary_n = 1'b0;
  logic depth_select_high = 1'b1;
  logic depth_select_low_n = 1'b0;
  logic processor_addr_strobe_n = 1'b1;
  logic controller_addr_strobe_n = 1'b1;
  logic burst_advance_n = 1'b1;
  logic global_write_n = 1'b1;
  logic byte_write_enable_n = 1'b1;
  logic [LANES-1:0] byte_lane_write_n = 4'hf;
  logic output_enable_n = 1'b0;
  logic sleep_request = 1'b0;
  logic burst_linear = 1'b0;
  logic array_stall = 1'b0;
  logic write_ready;
  logic [DATA_W-1:0] seen_r;
  int n_mismatch = 0;
  int check_count = 0;
  always #5 clock = ~clock;
  pipelined_burst_sram_port pipelined_burst_sram_port_i (.clock, .reset, .addr, .dq_in, .dq_out,
    .dq_oe, .chip_select_primary_n, .depth_select_high, .depth_select_low_n,
    .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_advance_n, .global_write_n,
    .byte_write_enable_n, .byte_lane_write_n, .output_enable_n, .sleep_request, .burst_linear,
    .array_stall, .write_ready);
  ctrl_capture ctrl_capture_i (.clock, .dq_oe, .dq_out, .seen_r);
  function automatic logic [DATA_W-1:0] pat(input logic [BEAT_W-1:0] lo);
    return {9'(lo), 9'h0a5, 9'(~lo), 9'h15a};
  endfunction
  task chk(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  // op codes: 0 idle, 1 read, 2 global write, 3 read by controller strobe, 4 deselect,
  // 5 lane write, 6 advance, 7 primary select off without strobe, 8 low select off without strobe
  task cyc(input int op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    input logic [LANES-1:0] ln);
    @(posedge clock);
    processor_addr_strobe_n <= !(op inside {1, 2, 4});
    controller_addr_strobe_n <= !(op inside {3, 5});
    depth_select_high <= (op != 4);
    chip_select_primary_n <= (op == 7);
    depth_select_low_n <= (op == 8);
    burst_advance_n <= (op != 6);
    global_write_n <= (op != 2);
    byte_write_enable_n <= (op != 5);
    byte_lane_write_n <= ln;
    addr <= a;
    dq_in <= d;
  endtask
  task idle(input int op);
    cyc(op, '0, '0, 4'hf);
  endtask
  task rd_chk(input int op, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln,
    input logic [DATA_W-1:0] e);
    cyc(op, a, '0, ln);
    idle(4);
    idle(0);
    idle(0);
    @(posedge clock);
    #1;
    chk("read word", e, seen_r);
  endtask
  task t_reset;
    repeat (9) @(posedge clock);
    #1;
    chk("ready in reset", '0, 36'(write_ready));
    @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    chk("ready after reset", 36'h1, 36'(write_ready));
  endtask
  task t_lanes;
    logic [DATA_W-1:0] p;
    logic [DATA_W-1:0] n;
    p = 36'h123456789;
    n = 36'hfedcba987;
    cyc(2, 19'h00040, p, 4'hf);
    rd_chk(1, 19'h00040, 4'hf, p);
    cyc(5, 19'h00040, n, 4'ha);
    rd_chk(3, 19'h00040, 4'h0, {p[35:27], n[26:18], p[17:9], n[8:0]});
  endtask
  task t_burst(input logic lin);
    logic [BEAT_W-1:0] lo;
    @(posedge clock);
    burst_linear <= lin;
    repeat (3) idle(0);
    for (int i = 0; i < 4; i++) cyc(2, {17'h00080, 2'(i)}, pat(2'(i)), 4'hf);
    cyc(1, {17'h00080, 2'h1}, '0, 4'hf);
    for (int b = 0; b < 7; b++)
    begin
      idle(b < 3 ? 6 : (b == 3 ? (lin ? 7 : 8) : 0));
      if (b >= 3)
      begin
        lo = lin ? 2'(b - 2) : 2'(1 ^ (b - 3));
        #1;
        chk("burst beat", pat(lo), seen_r);
      end
    end
  endtask
  task t_oe_sleep;
    cyc(1, 19'h00040, '0, 4'hf);
    repeat (3) idle(0);
    #1;
    chk("drive on", 36'h1, 36'(dq_oe));
    @(posedge clock);
    output_enable_n <= 1'b1;
    #1;
    chk("drive gated", '0, 36'(dq_oe));
    @(posedge clock);
    output_enable_n <= 1'b0;
    sleep_request <= 1'b1;
    #1;
    chk("drive in sleep", '0, 36'(dq_oe));
    @(posedge clock);
    sleep_request <= 1'b0;
    repeat (8) idle(0);
  endtask
  task t_stall;
    @(posedge clock);
    array_stall <= 1'b1;
    cyc(2, 19'h00300, 36'h111111111, 4'hf);
    cyc(2, 19'h00301, 36'h222222222, 4'hf);
    idle(4);
    @(posedge clock);
    #1;
    chk("ready when full", '0, 36'(write_ready));
    @(posedge clock);
    array_stall <= 1'b0;
    rd_chk(1, 19'h00300, 4'hf, 36'h111111111);
    rd_chk(1, 19'h00301, 4'hf, 36'h222222222);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_mismatch++;
    give_verdict();
  end
  initial
  begin
    t_reset();
    t_lanes();
    t_burst(1'b0);
    t_burst(1'b1);
    t_oe_sleep();
    t_stall();
    give_verdict();
  end
endmodule
